/* File: logic/adc_seq_defines.svh */
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// ----------------------------------------------------------------
// Written byte layout
// ----------------------------------------------------------------
`define BYTE_KIND_BIT 7
`define SEL_HI_BIT 6
`define SEL_LO_BIT 4
`define EXT_CLK_BIT 3
`define POLARITY_BIT 2
`define CS_HI_BIT 4
`define CS_LO_BIT 1
`define SINGLE_DIFF_BIT 0
`define REF_PIN_SEL_BIT 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEL_RESET 3'h0
`define EXT_CLK_RESET 1'b0
`define POLARITY_RESET 1'b0
`define CS_RESET 4'h0
`define SINGLE_DIFF_RESET 1'b1

// ----------------------------------------------------------------
// Timing and counts
// ----------------------------------------------------------------
`define CORE_CLK_PERIOD_NS 100
`define INT_CONV_CLK_PERIOD_NS 800
`define INT_DIV_CYCLES ((`INT_CONV_CLK_PERIOD_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS)
`define CONV_BITS 12
`define BYTE_BITS 8
`define ADDR_BITS 7
`define EXT_HOLD_PULSE 2
`define RESULT_PAD 4'hF

`endif

/* File: logic/adc_seq_pkg.sv */
package adc_seq_pkg;

	// ----------------------------------------------------------------
	// Serial slave states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [6:0]
	{
		st_idle = 7'h01,
		st_addr = 7'h02,
		st_addr_ack = 7'h04,
		st_conv = 7'h08,
		st_tx = 7'h10,
		st_tx_ack = 7'h20,
		st_rx = 7'h40
	} seq_state_e;

	// ----------------------------------------------------------------
	// Successive-approximation core state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic busy;
		logic done;
		logic [3:0] bit_idx;
		logic [11:0] trial;
		logic [11:0] result;
	} sar_state_s;

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic scl_s1;
		logic scl_s2;
		logic scl_d;
		logic sda_s1;
		logic sda_s2;
		logic sda_d;
		logic cmp_s1;
		logic cmp_s2;
		logic neg_s1;
		logic neg_s2;
		seq_state_e state;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] tx;
		logic is_read;
		logic addr_hit;
		logic low_byte;
		logic acked;
		logic [3:0] div_cnt;
		logic [2:0] ref_sel;
		logic ext_clk;
		logic polarity;
		logic [3:0] chan_sel;
		logic single_diff;
		logic track;
		logic scl_oe_n;
		logic sda_oe_n;
		logic sar_start;
		logic [3:0] mux_pos;
		logic [3:0] mux_neg;
		logic mux_neg_is_gnd;
		logic bipolar;
		logic ref_pin_is_reference;
		logic [11:0] result;
		logic result_valid;
	} seq_state_s;

endpackage : adc_seq_pkg

/* File: logic/conv_if.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Sequencer to conversion core link
// ----------------------------------------------------------------
interface conv_if;
	logic start;
	logic step;
	logic bipolar;
	logic cmp_hi;
	logic cmp_neg;
	logic busy;
	logic done;
	logic [11:0] result;
	logic [11:0] dac_code;

	modport ctrl
	(
		output start,
		output step,
		output bipolar,
		output cmp_hi,
		output cmp_neg,
		input busy,
		input done,
		input result,
		input dac_code
	);

	modport core
	(
		input start,
		input step,
		input bipolar,
		input cmp_hi,
		input cmp_neg,
		output busy,
		output done,
		output result,
		output dac_code
	);
endinterface : conv_if

/* File: logic/sar_core.sv */
`timescale 1ns/10ps
`include "adc_seq_defines.svh"

module sar_core
(
	input wire logic core_clk,
	input wire logic rst_n,
	conv_if.core cv
);

	// ----------------------------------------------------------------
	// Output coding
	// ----------------------------------------------------------------
	// Clamp wins over coding: a negative unipolar input must not wrap
	function automatic logic [11:0] code_result
	(
		input logic [11:0] raw,
		input logic bip,
		input logic neg
	);
		logic [11:0] res;
		res = raw;
		if (!bip && neg)
		begin
			res = 12'h000;
		end
		else if (bip)
		begin
			res = {~raw[11], raw[10:0]};
		end
		return res;
	endfunction : code_result

	adc_seq_pkg::sar_state_s st_r;
	adc_seq_pkg::sar_state_s st_nxt;

	// ----------------------------------------------------------------
	// One bit per conversion clock, MSB first
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.done = 1'b0;
		if (cv.start)
		begin
			st_nxt.busy = 1'b1;
			st_nxt.bit_idx = 4'(`CONV_BITS - 1);
			st_nxt.trial = 12'h800;
		end
		else if (st_r.busy && cv.step)
		begin
			if (!cv.cmp_hi)
			begin
				st_nxt.trial[st_r.bit_idx] = 1'b0;
			end
			if (st_r.bit_idx == 4'h0)
			begin
				st_nxt.busy = 1'b0;
				st_nxt.done = 1'b1;
				st_nxt.result = code_result(st_nxt.trial, cv.bipolar, cv.cmp_neg);
			end
			else
			begin
				st_nxt.trial[st_r.bit_idx - 4'h1] = 1'b1;
				st_nxt.bit_idx = st_r.bit_idx - 4'h1;
			end
		end
	end

	// Register the whole core state
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// DAC trial code comes straight from the trial register
	assign cv.busy = st_r.busy;
	assign cv.done = st_r.done;
	assign cv.result = st_r.result;
	assign cv.dac_code = st_r.trial;

endmodule : sar_core

/* File: logic/adc_track_hold_sequencer.sv */
`timescale 1ns/10ps
`include "adc_seq_defines.svh"


module adc_track_hold_sequencer
#(
	// Arbitrary neutral slave address
	parameter logic [6:0] dev_addr = 7'h2A
)
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic cmp_in,
	input wire logic cmp_neg_in,
	output logic scl_out,
	output logic scl_oe_n,
	output logic sda_out,
	output logic sda_oe_n,
	output logic track_hold,
	output logic [3:0] mux_pos,
	output logic [3:0] mux_neg,
	output logic mux_neg_is_gnd,
	output logic bipolar_active,
	output logic [2:0] ref_sel,
	output logic ref_pin_is_reference,
	output logic ext_clock_mode,
	output logic [11:0] dac_code,
	output logic [11:0] result,
	output logic result_valid
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic rst_s1_r;
	logic rst_n_r;

	// Async assert, release after two edges
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Upper result byte carries four fill ones above the top bits
	function automatic logic [7:0] high_byte(input logic [11:0] res);
		return {`RESULT_PAD, res[11:8]};
	endfunction : high_byte

	adc_seq_pkg::seq_state_s st_r;
	adc_seq_pkg::seq_state_s st_nxt;
	conv_if cv();

	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic div_tick;

	// ----------------------------------------------------------------
	// Bus events from synchronised lines
	// ----------------------------------------------------------------
	// Only the second sync stage and its delayed copy feed the detectors
	assign scl_rise = st_r.scl_s2 & ~st_r.scl_d;
	assign scl_fall = ~st_r.scl_s2 & st_r.scl_d;
	assign start_cond = st_r.scl_s2 & st_r.scl_d & st_r.sda_d & ~st_r.sda_s2;
	assign stop_cond = st_r.scl_s2 & st_r.scl_d & ~st_r.sda_d & st_r.sda_s2;
	assign div_tick = (st_r.state == adc_seq_pkg::st_conv) && (st_r.div_cnt == 4'(`INT_DIV_CYCLES - 1));

	// Conversion clock source depends on mode
	assign cv.start = st_r.sar_start;
	assign cv.step = st_r.ext_clk ? scl_rise : div_tick;
	assign cv.bipolar = st_r.bipolar;
	assign cv.cmp_hi = st_r.cmp_s2;
	assign cv.cmp_neg = st_r.neg_s2;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		st_nxt.scl_s1 = scl_in;
		st_nxt.scl_s2 = st_r.scl_s1;
		st_nxt.scl_d = st_r.scl_s2;
		st_nxt.sda_s1 = sda_in;
		st_nxt.sda_s2 = st_r.sda_s1;
		st_nxt.sda_d = st_r.sda_s2;
		st_nxt.cmp_s1 = cmp_in;
		st_nxt.cmp_s2 = st_r.cmp_s1;
		st_nxt.neg_s1 = cmp_neg_in;
		st_nxt.neg_s2 = st_r.neg_s1;
		st_nxt.sar_start = 1'b0;
		st_nxt.result_valid = 1'b0;

		// Latest finished conversion
		if (cv.done)
		begin
			st_nxt.result = cv.result;
			st_nxt.result_valid = 1'b1;
		end

		// Input multiplexer and coding mode from stored bytes
		if (st_r.single_diff)
		begin
			st_nxt.mux_pos = st_r.chan_sel;
			st_nxt.mux_neg = 4'h0;
			st_nxt.mux_neg_is_gnd = 1'b1;
			st_nxt.bipolar = 1'b0;
		end
		else
		begin
			st_nxt.mux_pos = st_r.chan_sel;
			st_nxt.mux_neg = {st_r.chan_sel[3:1], ~st_r.chan_sel[0]};
			st_nxt.mux_neg_is_gnd = 1'b0;
			st_nxt.bipolar = st_r.polarity;
		end
		st_nxt.ref_pin_is_reference = st_r.ref_sel[`REF_PIN_SEL_BIT];

		case (st_r.state)
			adc_seq_pkg::st_idle:
			begin
				st_nxt.bit_cnt = 4'h0;
			end
			adc_seq_pkg::st_addr:
			begin
				if (scl_rise)
				begin
					st_nxt.shift = {st_r.shift[6:0], st_r.sda_s2};
					st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
					if (st_r.bit_cnt == 4'(`ADDR_BITS))
					begin
						st_nxt.addr_hit = (st_r.shift[6:0] == dev_addr);
						st_nxt.is_read = st_r.sda_s2;
						if ((st_r.shift[6:0] == dev_addr) && st_r.sda_s2)
						begin
							st_nxt.track = 1'b1;
						end
					end
				end
				else if (scl_fall && (st_r.bit_cnt == 4'(`BYTE_BITS)))
				begin
					if (st_r.addr_hit)
					begin
						st_nxt.sda_oe_n = 1'b0;
						st_nxt.state = adc_seq_pkg::st_addr_ack;
					end
					else
					begin
						st_nxt.state = adc_seq_pkg::st_idle;
					end
				end
			end
			adc_seq_pkg::st_addr_ack:
			begin
				if (scl_fall)
				begin
					st_nxt.sda_oe_n = 1'b1;
					st_nxt.bit_cnt = 4'h0;
					st_nxt.low_byte = 1'b0;
					if (!st_r.is_read)
					begin
						st_nxt.state = adc_seq_pkg::st_rx;
					end
					else if (!st_r.ext_clk)
					begin
						// Stretch the clock so the master waits for the result
						st_nxt.track = 1'b0;
						st_nxt.sar_start = 1'b1;
						st_nxt.scl_oe_n = 1'b0;
						st_nxt.div_cnt = 4'h0;
						st_nxt.state = adc_seq_pkg::st_conv;
					end
					else
					begin
						st_nxt.tx = high_byte(st_r.result);
						st_nxt.sda_oe_n = st_nxt.tx[7];
						st_nxt.state = adc_seq_pkg::st_tx;
					end
				end
			end
			adc_seq_pkg::st_conv:
			begin
				st_nxt.div_cnt = div_tick ? 4'h0 : st_r.div_cnt + 4'h1;
				if (cv.done)
				begin
					// First data bit set up in the same cycle as the clock is let go
					st_nxt.tx = high_byte(cv.result);
					st_nxt.sda_oe_n = st_nxt.tx[7];
					st_nxt.scl_oe_n = 1'b1;
					st_nxt.state = adc_seq_pkg::st_tx;
				end
			end
			adc_seq_pkg::st_tx:
			begin
				if (scl_rise)
				begin
					st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
					// Hold only once, on the first byte after the address
					if (st_r.ext_clk && st_r.track && !st_r.low_byte &&
						(st_r.bit_cnt == 4'(`EXT_HOLD_PULSE - 1)))
					begin
						st_nxt.track = 1'b0;
						st_nxt.sar_start = 1'b1;
					end
				end
				else if (scl_fall)
				begin
					if (st_r.bit_cnt == 4'(`BYTE_BITS))
					begin
						st_nxt.sda_oe_n = 1'b1;
						st_nxt.state = adc_seq_pkg::st_tx_ack;
					end
					else
					begin
						st_nxt.tx = {st_r.tx[6:0], 1'b0};
						st_nxt.sda_oe_n = st_r.tx[6];
					end
				end
			end
			adc_seq_pkg::st_tx_ack:
			begin
				if (scl_rise)
				begin
					st_nxt.acked = ~st_r.sda_s2;
				end
				else if (scl_fall)
				begin
					if (st_r.acked)
					begin
						// Bytes alternate high, low, high of the latest result
						st_nxt.low_byte = ~st_r.low_byte;
						st_nxt.tx = st_r.low_byte ? high_byte(st_r.result) : st_r.result[7:0];
						st_nxt.sda_oe_n = st_nxt.tx[7];
						st_nxt.bit_cnt = 4'h0;
						st_nxt.state = adc_seq_pkg::st_tx;
					end
					else
					begin
						st_nxt.state = adc_seq_pkg::st_idle;
					end
				end
			end
			adc_seq_pkg::st_rx:
			begin
				if (scl_rise && (st_r.bit_cnt != 4'(`BYTE_BITS)))
				begin
					st_nxt.shift = {st_r.shift[6:0], st_r.sda_s2};
					st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
				end
				else if (scl_fall && (st_r.bit_cnt == 4'(`BYTE_BITS)) && st_r.sda_oe_n)
				begin
					if (st_r.shift[`BYTE_KIND_BIT])
					begin
						st_nxt.ref_sel = st_r.shift[`SEL_HI_BIT:`SEL_LO_BIT];
						st_nxt.ext_clk = st_r.shift[`EXT_CLK_BIT];
						st_nxt.polarity = st_r.shift[`POLARITY_BIT];
					end
					else
					begin
						st_nxt.chan_sel = st_r.shift[`CS_HI_BIT:`CS_LO_BIT];
						st_nxt.single_diff = st_r.shift[`SINGLE_DIFF_BIT];
					end
					st_nxt.sda_oe_n = 1'b0;
				end
				else if (scl_fall && !st_r.sda_oe_n)
				begin
					// Acknowledge pulse over, next byte
					st_nxt.sda_oe_n = 1'b1;
					st_nxt.bit_cnt = 4'h0;
				end
			end
			default:
			begin
				st_nxt.state = adc_seq_pkg::st_idle;
			end
		endcase

		// Bus conditions abort anything but a running stretched conversion
		if (st_r.state != adc_seq_pkg::st_conv)
		begin
			if (start_cond)
			begin
				st_nxt.state = adc_seq_pkg::st_addr;
				st_nxt.bit_cnt = 4'h0;
				st_nxt.sda_oe_n = 1'b1;
				st_nxt.track = 1'b0;
			end
			else if (stop_cond)
			begin
				st_nxt.state = adc_seq_pkg::st_idle;
				st_nxt.sda_oe_n = 1'b1;
				st_nxt.track = 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Lines reset high so release does not look like a start
	always_ff @(posedge core_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			st_r <= '0;
			st_r.scl_s1 <= 1'b1;
			st_r.scl_s2 <= 1'b1;
			st_r.scl_d <= 1'b1;
			st_r.sda_s1 <= 1'b1;
			st_r.sda_s2 <= 1'b1;
			st_r.sda_d <= 1'b1;
			st_r.state <= adc_seq_pkg::st_idle;
			st_r.ref_sel <= `SEL_RESET;
			st_r.ext_clk <= `EXT_CLK_RESET;
			st_r.polarity <= `POLARITY_RESET;
			st_r.chan_sel <= `CS_RESET;
			st_r.single_diff <= `SINGLE_DIFF_RESET;
			st_r.mux_neg_is_gnd <= 1'b1;
			st_r.scl_oe_n <= 1'b1;
			st_r.sda_oe_n <= 1'b1;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Conversion core
	// ----------------------------------------------------------------
	sar_core u_sar
	(
		.core_clk(core_clk),
		.rst_n(rst_n_r),
		.cv(cv.core)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open-drain: only the enables move, drive level is always low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe_n = st_r.scl_oe_n;
	assign sda_oe_n = st_r.sda_oe_n;
	assign track_hold = st_r.track;
	assign mux_pos = st_r.mux_pos;
	assign mux_neg = st_r.mux_neg;
	assign mux_neg_is_gnd = st_r.mux_neg_is_gnd;
	assign bipolar_active = st_r.bipolar;
	assign ref_sel = st_r.ref_sel;
	assign ref_pin_is_reference = st_r.ref_pin_is_reference;
	assign ext_clock_mode = st_r.ext_clk;
	assign dac_code = cv.dac_code;
	assign result = st_r.result;
	assign result_valid = st_r.result_valid;

endmodule : adc_track_hold_sequencer

/* File: tb/adc_seq_asserts.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Port checker for the track/hold sequencer
// ----------------------------------------------------------------
module adc_seq_asserts
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic scl_oe_n,
	input wire logic track_hold,
	input wire logic [3:0] mux_pos,
	input wire logic [3:0] mux_neg,
	input wire logic mux_neg_is_gnd,
	input wire logic bipolar_active,
	input wire logic [2:0] ref_sel,
	input wire logic ref_pin_is_reference,
	input wire logic ext_clock_mode,
	input wire logic [11:0] result,
	input wire logic result_valid
);
	logic [7:0] low_cnt_r;
	logic [7:0] trk_cnt_r;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	// Length of clock stretch and of track phase, in core cycles
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			low_cnt_r <= 8'h00;
			trk_cnt_r <= 8'h00;
		end
		else
		begin
			low_cnt_r <= scl_oe_n ? 8'h00 : low_cnt_r + 8'h01;
			trk_cnt_r <= track_hold ? trk_cnt_r + 8'h01 : 8'h00;
		end
	end

	// Held sample while the bus clock is stretched
	sequence s_held;
		(!track_hold && !scl_oe_n) [*8];
	endsequence
	// Release ends with a single result strobe
	sequence s_strobe;
		result_valid ##1 !result_valid;
	endsequence

	property p_stretch_hold;
		$fell(scl_oe_n) |-> $fell(track_hold) ##1 s_held;
	endproperty
	a_stretch_hold: assert property (p_stretch_hold) else $error("hold not entered at stretch");
	property p_release;
		$rose(scl_oe_n) |-> s_strobe;
	endproperty
	a_release: assert property (p_release) else $error("stretch ended without result");
	// Twelve steps of eight core cycles each
	property p_stretch_len;
		$rose(scl_oe_n) |-> low_cnt_r inside {[95:101]};
	endproperty
	a_stretch_len: assert property (p_stretch_len) else $error("conversion length wrong");
	// Internal track from eighth rise to ninth fall, external three rises
	property p_track_len;
		$fell(track_hold) |-> (ext_clock_mode ? trk_cnt_r inside {[23:25]} : trk_cnt_r inside {[11:13]});
	endproperty
	a_track_len: assert property (p_track_len) else $error("track length wrong");
	property p_ext_no_stretch;
		ext_clock_mode |-> scl_oe_n;
	endproperty
	a_ext_no_stretch: assert property (p_ext_no_stretch) else $error("stretch in external mode");
	property p_result_stable;
		!result_valid |-> $stable(result);
	endproperty
	a_result_stable: assert property (p_result_stable) else $error("result moved without strobe");
	property p_single_gnd;
		$past(mux_neg_is_gnd) && mux_neg_is_gnd |-> !bipolar_active && mux_neg == 4'h0;
	endproperty
	a_single_gnd: assert property (p_single_gnd) else $error("single-ended not unipolar");
	property p_diff_pair;
		$stable(mux_pos) && !mux_neg_is_gnd |-> mux_neg == (mux_pos ^ 4'h1);
	endproperty
	a_diff_pair: assert property (p_diff_pair) else $error("differential pair wrong");
	// Pin use is registered from the stored select, so it trails it by a cycle
	property p_ref_pin;
		ref_pin_is_reference == $past(ref_sel[1]);
	endproperty
	a_ref_pin: assert property (p_ref_pin) else $error("reference pin use wrong");
endmodule : adc_seq_asserts

bind adc_track_hold_sequencer adc_seq_asserts chk (.*);

/* File: tb/bus_master_model.sv */
`timescale 1ns/10ps

// ----------------------------------------------------------------
// Two-wire master, both lines pulled up
// ----------------------------------------------------------------
module bus_master_model
(
	input wire logic core_clk,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	output logic scl_line,
	output logic sda_line,
	output logic stall_err
);
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;

	// Wired-and; released lines float high
	assign scl_line = m_scl & (scl_oe_n | scl_out);
	assign sda_line = m_sda & (sda_oe_n | sda_out);
	initial stall_err = 1'b0;

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	// One bit, 800 ns unless the device stretches the clock
	task automatic bit_xfer(input logic b, output logic r);
		int n;
		m_sda = b;
		tick(2);
		m_scl = 1'b1;
		tick(2);
		n = 0;
		while (scl_line !== 1'b1 && n < 300)
		begin
			tick(1);
			n++;
		end
		if (n == 300)
			stall_err = 1'b1;
		r = sda_line;
		tick(2);
		m_scl = 1'b0;
		tick(2);
	endtask : bit_xfer

	task automatic byte_xfer(input logic [7:0] d, input logic ack_out, output logic [7:0] q, output logic ack_in);
		for (int i = 7; i >= 0; i--)
			bit_xfer(d[i], q[i]);
		bit_xfer(ack_out, ack_in);
	endtask : byte_xfer

	task automatic start_cond();
		m_sda = 1'b1;
		tick(2);
		m_scl = 1'b1;
		tick(4);
		m_sda = 1'b0;
		tick(4);
		m_scl = 1'b0;
		tick(2);
	endtask : start_cond

	task automatic stop_cond();
		m_sda = 1'b0;
		tick(2);
		m_scl = 1'b1;
		tick(4);
		m_sda = 1'b1;
		tick(8);
	endtask : stop_cond
endmodule : bus_master_model

/* File: tb/test_adc_track_hold_sequencer.sv */
`timescale 1ns/10ps

module test_adc_track_hold_sequencer;
	// Arbitrary slave address
	localparam logic [6:0] dev_addr = 7'h2A;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic cmp_in = 1'b0;
	logic cmp_neg_in = 1'b0;
	logic scl_line, sda_line, stall_err, scl_out, scl_oe_n, sda_out, sda_oe_n, track_hold;
	logic mux_neg_is_gnd, bipolar_active, ref_pin_is_reference, ext_clock_mode, result_valid, vneg;
	logic [3:0] mux_pos, mux_neg;
	logic [2:0] ref_sel;
	logic [11:0] dac_code, result, prev;
	logic [11:0] vin = 12'h000;
	logic [31:0] seed = 32'h0000_004A;
	logic [11:0] exp_q[$];
	int fail_count = 0;
	int cmp_count = 0;

	always #50 core_clk = ~core_clk;

	adc_track_hold_sequencer #(.dev_addr(dev_addr)) uut
	(
		.core_clk(core_clk),
		.rstn(rstn),
		.scl_in(scl_line),
		.sda_in(sda_line),
		.cmp_in(cmp_in),
		.cmp_neg_in(cmp_neg_in),
		.scl_out(scl_out),
		.scl_oe_n(scl_oe_n),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.track_hold(track_hold),
		.mux_pos(mux_pos),
		.mux_neg(mux_neg),
		.mux_neg_is_gnd(mux_neg_is_gnd),
		.bipolar_active(bipolar_active),
		.ref_sel(ref_sel),
		.ref_pin_is_reference(ref_pin_is_reference),
		.ext_clock_mode(ext_clock_mode),
		.dac_code(dac_code),
		.result(result),
		.result_valid(result_valid)
	);

	bus_master_model mst
	(
		.core_clk(core_clk),
		.scl_out(scl_out),
		.scl_oe_n(scl_oe_n),
		.sda_out(sda_out),
		.sda_oe_n(sda_oe_n),
		.scl_line(scl_line),
		.sda_line(sda_line),
		.stall_err(stall_err)
	);

	// Comparator stand-in: input level against trial code
	always @(posedge core_clk)
	begin
		#1;
		cmp_in = (vin >= dac_code);
		cmp_neg_in = vneg;
	end

	task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	// Result strobe takes the oldest expected code
	always @(posedge core_clk)
	begin
		#1;
		if (result_valid === 1'b1 && exp_q.size() == 0)
			check("result_valid", 12'(result_valid), 12'h000);
		else if (result_valid === 1'b1)
			check("result", result, exp_q.pop_front());
	end

	// Hang guards
	initial
	begin
		repeat (90000) @(posedge core_clk);
		fail_count++;
		complete_run();
	end
	always @(posedge stall_err)
	begin
		fail_count++;
		complete_run();
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	// Unipolar clamps negative input, bipolar flips the top bit
	function automatic logic [11:0] coded(input logic [11:0] v, input logic n, input logic bip);
		if (bip)
			return v ^ 12'h800;
		return n ? 12'h000 : v;
	endfunction : coded

	task automatic write_bytes(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] q;
		logic ack;
		mst.start_cond();
		mst.byte_xfer({dev_addr, 1'b0}, 1'b1, q, ack);
		check("address ack", 12'(ack), 12'h000);
		mst.byte_xfer(a, 1'b1, q, ack);
		check("data ack", 12'(ack), 12'h000);
		mst.byte_xfer(b, 1'b1, q, ack);
		check("data ack", 12'(ack), 12'h000);
		mst.stop_cond();
	endtask : write_bytes

	// Two result bytes, high first, master stops with a not-acknowledge
	task automatic read_result(input logic [11:0] exp);
		logic [7:0] hi;
		logic [7:0] lo;
		logic ack;
		mst.start_cond();
		mst.byte_xfer({dev_addr, 1'b1}, 1'b1, hi, ack);
		check("address ack", 12'(ack), 12'h000);
		mst.byte_xfer(8'hFF, 1'b0, hi, ack);
		mst.byte_xfer(8'hFF, 1'b1, lo, ack);
		mst.stop_cond();
		check("high byte", {hi, 4'h0}, {4'hF, exp[11:8], 4'h0});
		check("low byte", 12'(lo), 12'(exp[7:0]));
	endtask : read_result

	initial
	begin
		logic [11:0] e;
		logic [7:0] q;
		logic ack;
		logic sd;
		logic pol;
		vneg = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		mst.tick(8);
		check("result", result, 12'h000);
		check("dac_code", dac_code, 12'h000);
		check("drive level", 12'({scl_out, sda_out}), 12'h000);
		check("ground side", 12'(mux_neg_is_gnd), 12'h001);
		// Each input mode once, random channel, reference and level
		for (int i = 0; i < 4; i++)
		begin
			seed = xs(seed);
			sd = i[0];
			pol = i[1];
			vin = seed[19:8];
			vneg = !sd && (i == 0 || seed[20]);
			write_bytes({1'b1, seed[6:4], 1'b0, pol, 2'b00}, {3'b000, seed[3:0], sd});
			check("mux_pos", 12'(mux_pos), 12'(seed[3:0]));
			check("mux_neg", 12'(mux_neg), sd ? 12'h000 : 12'(seed[3:0] ^ 4'h1));
			check("ground side", 12'(mux_neg_is_gnd), 12'(sd));
			check("bipolar", 12'(bipolar_active), 12'(!sd && pol));
			check("ref_sel", 12'(ref_sel), 12'(seed[6:4]));
			e = coded(vin, vneg, !sd && pol);
			exp_q.push_back(e);
			read_result(e);
			// Trial register ends on the raw approximation of the input
			check("dac_code", dac_code, vin);
			prev = e;
		end
		// Foreign address is ignored
		mst.start_cond();
		mst.byte_xfer({dev_addr ^ 7'h01, 1'b1}, 1'b1, q, ack);
		check("foreign ack", 12'(ack), 12'h001);
		check("track", 12'(track_hold), 12'h000);
		mst.stop_cond();
		// External clock: each read returns the earlier code and converts anew
		seed = xs(seed);
		vin = seed[11:0];
		vneg = 1'b0;
		write_bytes(8'h88, 8'h01);
		check("clock mode", 12'(ext_clock_mode), 12'h001);
		e = vin;
		repeat (2)
		begin
			exp_q.push_back(e);
			read_result(prev);
			prev = e;
		end
		for (int n = 0; n < 200 && exp_q.size() > 0; n++)
			mst.tick(1);
		check("pending results", 12'(exp_q.size()), 12'h000);
		check("dac_code", dac_code, vin);
		complete_run();
	end
endmodule : test_adc_track_hold_sequencer
